//--- irq_prio_pkg.sv
// constants, field layout and carrier types of the interrupt priority controller
// assumes a single 125 MHz clock and a zero-wait AHB-Lite slave port
package irq_prio_pkg;

    // register array sizes
    localparam int unsigned NUM_FLAG_REGS = 7;
    localparam int unsigned NUM_PRI_REGS  = 28;
    localparam int unsigned SRC_PER_PRI   = 4;
    localparam int unsigned REG_W         = 16;

    // byte offsets inside the slave window
    localparam logic [11:0] OFS_CTL1      = 12'h000;
    localparam logic [11:0] OFS_CTL2      = 12'h004;
    localparam logic [11:0] OFS_STATUS    = 12'h008;
    localparam logic [11:0] OFS_CORE      = 12'h00c;
    localparam logic [11:0] OFS_VLATCH    = 12'h010;
    localparam logic [11:0] OFS_EVT_STAT  = 12'h014;
    localparam logic [11:0] OFS_EVT_MASK  = 12'h018;
    localparam logic [3:0]  PAGE_FLAGS    = 4'h1;
    localparam logic [3:0]  PAGE_ENABLES  = 4'h2;
    localparam logic [3:0]  PAGE_PRIO     = 4'h3;

    // field positions
    localparam int unsigned NEST_BIT      = 15;
    localparam int unsigned TRAP_LSB      = 1;
    localparam int unsigned TRAP_W        = 4;
    localparam int unsigned ALT_BIT       = 15;
    localparam int unsigned EDGE_W        = 3;
    localparam int unsigned LEVEL_LSB     = 5;
    localparam int unsigned TOP_BIT       = 3;
    localparam int unsigned PSV_BIT       = 2;
    localparam int unsigned VEC_W         = 7;
    localparam int unsigned LVL_W         = 4;
    localparam int unsigned PRI_W         = 3;
    localparam int unsigned LVL_FIELD_LSB = 8;

    // which priority registers exist
    localparam logic [27:0] PRI_IMPL      = 28'h11d94ff;

    // values after reset
    localparam logic [15:0] CTL_RST       = 16'h0000;
    localparam logic [15:0] FLAG_RST      = 16'h0000;
    localparam logic [15:0] PRI_RST       = 16'h0000;
    localparam logic [2:0]  LEVEL_RST     = 3'h0;

    // sticky event bits
    localparam int unsigned EVT_TRAP      = 0;
    localparam int unsigned EVT_ACCEPT    = 1;
    localparam int unsigned EVT_W         = 2;

    typedef struct packed {
        logic [VEC_W-1:0] vector;
        logic [LVL_W-1:0] level;
    } irq_req_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
    } bus_cmd_t;

endpackage

//--- irq_prio_ctrl.sv
// interrupt request flags, enables, priorities and cpu priority level
// assumes sources and cpu core sit on hclk; registers reached over AHB-Lite
`timescale 1ns/100ps
`default_nettype none

module irq_prio_ctrl
    import irq_prio_pkg::*;
#(
    parameter int unsigned NSRC = NUM_FLAG_REGS * REG_W
) (
    // clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // ahb-lite slave
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic      [31:0]      hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    // request sources
    input  wire logic [NSRC-1:0]  src_event,
    input  wire logic [TRAP_W-1:0] trap_event,
    input  wire logic             trap_raise_level,
    // cpu core
    output irq_req_t              cpu_req,
    output logic                  cpu_req_valid,
    input  wire logic             cpu_ack,
    output logic [LVL_W-1:0]      cpu_priority_level,
    output logic                  alternate_table_select,
    output logic [EDGE_W-1:0]     external_edge_select,
    // interrupt to system
    output logic                  irq
);

    localparam int unsigned NF = NUM_FLAG_REGS;
    localparam int unsigned NP = NUM_PRI_REGS;

    logic [15:0]         ctl1_q;
    logic [15:0]         ctl2_q;
    logic [2:0]          level_low_q;
    logic                top_bit_q;
    logic                psv_q;
    irq_req_t            vlatch_q;
    logic [EVT_W-1:0]    evt_stat_q;
    logic [EVT_W-1:0]    evt_mask_q;
    logic [NSRC-1:0]     flags_q;
    logic [NSRC-1:0]     enables_q;
    logic [15:0]         pri_q [NP];
    bus_cmd_t            cmd_q;
    irq_req_t            cand_d;
    logic                cand_found_d;
    logic                accept;
    logic                sw_wr;
    logic [15:0]         wdata;
    logic [EVT_W-1:0]    evt_in;

    // slave decode and address phase capture
    function automatic logic is_word(input logic [11:0] a, input logic [11:0] ofs);
        return a == ofs;
    endfunction

    function automatic logic [2:0] src_prio(input int unsigned s,
                                             input logic [15:0] p [NP]);
        logic [15:0] r;
        r = p[s / SRC_PER_PRI];
        return r[(s % SRC_PER_PRI) * 4 +: PRI_W];
    endfunction

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_q <= '0;
        end else if (hready) begin
            cmd_q.wr   <= hsel && htrans[1] && hwrite;
            cmd_q.rd   <= hsel && htrans[1] && !hwrite;
            cmd_q.addr <= haddr[11:0];
        end
    end

    // zero wait, always okay; narrow writes land in the low lanes
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign sw_wr     = cmd_q.wr;
    assign wdata     = hwdata[15:0];

    // highest priority eligible source, lowest index on a tie
    // eligibility and compare
    always_comb begin
        logic [2:0] p;
        logic [2:0] best;
        p            = 3'h0;
        best         = 3'h0;
        cand_found_d = 1'b0;
        cand_d       = '0;
        for (int unsigned s = 0; s < NSRC; s++) begin
            p = src_prio(s, pri_q);
            if (flags_q[s] && enables_q[s] && ({1'b0, p} > cpu_priority_level)
                && (!cand_found_d || p > best)) begin
                cand_found_d  = 1'b1;
                best          = p;
                cand_d.vector = VEC_W'(s);
                cand_d.level  = {1'b0, p};
            end
        end
    end

    // registered offer to the core; one cycle behind the flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_req       <= '0;
            cpu_req_valid <= 1'b0;
        end else begin
            cpu_req       <= cand_d;
            cpu_req_valid <= cand_found_d && !(cpu_ack && cpu_req_valid);
        end
    end

    assign accept = cpu_req_valid && cpu_ack;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vlatch_q <= '0;
        end else if (accept) begin
            vlatch_q <= cpu_req;
        end
    end

    // sticky flags, set beats software clear
    // bit s%16 of flag word s/16 is source s
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_q <= '0;
        end else begin
            for (int unsigned r = 0; r < NF; r++) begin
                if (sw_wr && cmd_q.addr[11:8] == PAGE_FLAGS
                    && cmd_q.addr[7:2] == 6'(r)) begin
                    flags_q[r*REG_W +: REG_W] <= wdata;
                end
            end
            flags_q <= flags_q | src_event;
            for (int unsigned r = 0; r < NF; r++) begin
                if (sw_wr && cmd_q.addr[11:8] == PAGE_FLAGS
                    && cmd_q.addr[7:2] == 6'(r)) begin
                    flags_q[r*REG_W +: REG_W] <= wdata | src_event[r*REG_W +: REG_W];
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enables_q <= '0;
        end else begin
            for (int unsigned r = 0; r < NF; r++) begin
                if (sw_wr && cmd_q.addr[11:8] == PAGE_ENABLES
                    && cmd_q.addr[7:2] == 6'(r)) begin
                    enables_q[r*REG_W +: REG_W] <= wdata;
                end
            end
        end
    end

    // only listed priority words hold state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int unsigned r = 0; r < NP; r++) begin
                pri_q[r] <= PRI_RST;
            end
        end else begin
            for (int unsigned r = 0; r < NP; r++) begin
                if (sw_wr && PRI_IMPL[r] && cmd_q.addr[11:8] == PAGE_PRIO
                    && cmd_q.addr[7:2] == 6'(r)) begin
                    pri_q[r] <= wdata & 16'h7777;
                end
            end
        end
    end

    // nesting bit plus trap status flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl1_q <= CTL_RST;
        end else begin
            if (sw_wr && is_word(cmd_q.addr, OFS_CTL1)) begin
                ctl1_q[NEST_BIT] <= wdata[NEST_BIT];
                ctl1_q[TRAP_LSB +: TRAP_W] <= wdata[TRAP_LSB +: TRAP_W] | trap_event;
            end else begin
                ctl1_q[TRAP_LSB +: TRAP_W] <= ctl1_q[TRAP_LSB +: TRAP_W] | trap_event;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl2_q <= CTL_RST;
        end else if (sw_wr && is_word(cmd_q.addr, OFS_CTL2)) begin
            ctl2_q[ALT_BIT]         <= wdata[ALT_BIT];
            ctl2_q[EDGE_W-1:0]      <= wdata[EDGE_W-1:0];
        end
    end

    assign alternate_table_select = ctl2_q[ALT_BIT];
    assign external_edge_select   = ctl2_q[EDGE_W-1:0];

    // low level bits, hardware beats software
    // software write ignored while nesting disabled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_low_q <= LEVEL_RST;
        end else if (accept) begin
            level_low_q <= cpu_req.level[2:0];
        end else if (sw_wr && is_word(cmd_q.addr, OFS_STATUS) && !ctl1_q[NEST_BIT]) begin
            level_low_q <= wdata[LEVEL_LSB +: 3];
        end
    end

    // software may only clear the top bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            top_bit_q <= 1'b0;
            psv_q     <= 1'b0;
        end else begin
            if (trap_raise_level) begin
                top_bit_q <= 1'b1;
            end else if (accept) begin
                top_bit_q <= cpu_req.level[3];
            end else if (sw_wr && is_word(cmd_q.addr, OFS_CORE) && !wdata[TOP_BIT]) begin
                top_bit_q <= 1'b0;
            end
            if (sw_wr && is_word(cmd_q.addr, OFS_CORE)) begin
                psv_q <= wdata[PSV_BIT];
            end
        end
    end

    // top bit over the status bits
    // top set means level above seven
    assign cpu_priority_level = {top_bit_q, level_low_q};

    // sticky events, write one to clear, new event wins
    assign evt_in = {accept, |trap_event};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt_stat_q <= '0;
            evt_mask_q <= '0;
        end else begin
            if (sw_wr && is_word(cmd_q.addr, OFS_EVT_STAT)) begin
                evt_stat_q <= (evt_stat_q & ~wdata[EVT_W-1:0]) | evt_in;
            end else begin
                evt_stat_q <= evt_stat_q | evt_in;
            end
            if (sw_wr && is_word(cmd_q.addr, OFS_EVT_MASK)) begin
                evt_mask_q <= wdata[EVT_W-1:0];
            end
        end
    end

    assign irq = |(evt_stat_q & evt_mask_q);

    // read mux over flops; unmapped offsets read zero
    // unused status and core bits zero
    always_comb begin
        logic [15:0] r;
        logic [5:0]  idx;
        r   = 16'h0000;
        idx = cmd_q.addr[7:2];
        case (cmd_q.addr[11:8])
            4'h0: begin
                if (is_word(cmd_q.addr, OFS_CTL1)) begin
                    r = ctl1_q;
                end else if (is_word(cmd_q.addr, OFS_CTL2)) begin
                    r = ctl2_q;
                end else if (is_word(cmd_q.addr, OFS_STATUS)) begin
                    r[LEVEL_LSB +: 3] = level_low_q;
                end else if (is_word(cmd_q.addr, OFS_CORE)) begin
                    r[TOP_BIT] = top_bit_q;
                    r[PSV_BIT] = psv_q;
                end else if (is_word(cmd_q.addr, OFS_VLATCH)) begin
                    r[VEC_W-1:0] = vlatch_q.vector;
                    r[LVL_FIELD_LSB +: LVL_W] = vlatch_q.level;
                end else if (is_word(cmd_q.addr, OFS_EVT_STAT)) begin
                    r[EVT_W-1:0] = evt_stat_q;
                end else if (is_word(cmd_q.addr, OFS_EVT_MASK)) begin
                    r[EVT_W-1:0] = evt_mask_q;
                end
            end
            PAGE_FLAGS: begin
                if (idx < 6'(NF)) begin
                    r = flags_q[idx*REG_W +: REG_W];
                end
            end
            PAGE_ENABLES: begin
                if (idx < 6'(NF)) begin
                    r = enables_q[idx*REG_W +: REG_W];
                end
            end
            PAGE_PRIO: begin
                if (idx < 6'(NP)) begin
                    r = pri_q[idx[4:0]];
                end
            end
            default: r = 16'h0000;
        endcase
        hrdata = cmd_q.rd ? {16'h0000, r} : 32'h0000_0000;
    end

    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence seq_accept;
        cpu_req_valid && cpu_ack;
    endsequence

    sequence seq_level_write;
        sw_wr && is_word(cmd_q.addr, OFS_STATUS) && !accept;
    endsequence

    a_flag_sticky: assert property (
        src_event[0] |=> flags_q[0]
    ) else $error("source event did not set its flag");

    a_enable_gate: assert property (
        cpu_req_valid |-> $past(enables_q[cand_d.vector])
    ) else $error("disabled source offered to core");

    a_latch_vector: assert property (
        seq_accept |=> vlatch_q.vector == $past(cpu_req.vector)
    ) else $error("vector not latched on accept");

    a_latch_level: assert property (
        seq_accept |=> vlatch_q.level == {1'b0, src_prio(32'($past(cpu_req.vector)), pri_q)}
    ) else $error("latched level differs from source priority");

    a_level_follows: assert property (
        seq_accept and !trap_raise_level |=> cpu_priority_level == vlatch_q.level
    ) else $error("cpu level not raised to accepted level");

    a_top_no_set: assert property (
        !trap_raise_level && !accept |=> !$rose(top_bit_q)
    ) else $error("top level bit set without trap");

    a_nest_lock: assert property (
        seq_level_write and ctl1_q[NEST_BIT] |=> $stable(level_low_q)
    ) else $error("level changed by software while nesting disabled");

    a_level_seven: assert property (
        (cpu_priority_level >= 4'h7) [*2] |-> !cpu_req_valid
    ) else $error("user interrupt offered at level seven");

    a_status_zero: assert property (
        cmd_q.rd && is_word(cmd_q.addr, OFS_STATUS) |-> hrdata[15:8] == 8'h00
    ) else $error("unimplemented status bits not zero");

    a_offer_above: assert property (
        cpu_req_valid |-> $past(flags_q[cand_d.vector])
            && cpu_req.level > $past(cpu_priority_level)
    ) else $error("offered level not above cpu level");

endmodule

`default_nettype wire

//--- cpu_core_model.sv
// behavioural cpu core: accepts offered interrupts after a chosen wait
// assumes the offer and the acknowledge both sit on hclk
`timescale 1ns/100ps
`default_nettype none
module cpu_core_model
    import irq_prio_pkg::*;
(
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // offer from the controller
    input  wire logic       cpu_req_valid,
    input  wire irq_req_t   cpu_req,
    // acknowledge wait and results
    input  wire logic [7:0] delay,
    output logic            cpu_ack,
    output irq_req_t        last,
    output int              n_taken
);
    logic [7:0] wait_q;

    // ack is a one-cycle pulse; a dropped offer restarts the wait
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_q  <= 8'h00;
            cpu_ack <= 1'b0;
            n_taken <= 0;
            last    <= '0;
        end else begin
            cpu_ack <= 1'b0;
            if (cpu_req_valid && cpu_ack) begin
                last    <= cpu_req;
                n_taken <= n_taken + 1;
                wait_q  <= 8'h00;
            end else if (!cpu_req_valid) begin
                wait_q <= 8'h00;
            end else if (wait_q >= delay) begin
                cpu_ack <= 1'b1;
            end else begin
                wait_q <= wait_q + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

//--- test_interrupt_priority_control.sv
// self-checking bench of the interrupt priority controller
// assumes a zero-wait AHB-Lite slave and the core model beside it
`timescale 1ns/100ps
`default_nettype none
module test_interrupt_priority_control;
    import irq_prio_pkg::*;
    localparam int NS = NUM_FLAG_REGS * REG_W;
    logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0]       haddr, hwdata, hrdata, rng, rd, msk;
    logic [1:0]        htrans;
    logic [2:0]        hsize;
    logic [NS-1:0]     src_event, m;
    logic [TRAP_W-1:0] trap_event;
    logic              trap_raise_level, cpu_req_valid, cpu_ack, alt_sel, irq;
    irq_req_t          cpu_req, last;
    logic [LVL_W-1:0]  cpu_priority_level;
    logic [EDGE_W-1:0] edge_sel;
    logic [7:0]        delay;
    logic [11:0]       ofs [10];
    int                n_taken, n_mismatch, comparisons, cyc, s;
    int                flg [NS], en [NS], pr [NS], lvl;

    irq_prio_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src_event(src_event),
        .trap_event(trap_event), .trap_raise_level(trap_raise_level), .cpu_req(cpu_req),
        .cpu_req_valid(cpu_req_valid), .cpu_ack(cpu_ack),
        .cpu_priority_level(cpu_priority_level), .alternate_table_select(alt_sel),
        .external_edge_select(edge_sel), .irq(irq));
    cpu_core_model core (.hclk(hclk), .hresetn(hresetn), .cpu_req_valid(cpu_req_valid),
        .cpu_req(cpu_req), .delay(delay), .cpu_ack(cpu_ack), .last(last), .n_taken(n_taken));

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    task close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // a hang ends the run as a failure
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        haddr  <= {20'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task rcheck(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    function logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    // highest priority wins, lowest index on a tie
    function int pick();
        int b;
        b = -1;
        for (int i = 0; i < NS; i++)
            if (flg[i] != 0 && en[i] != 0 && pr[i] > lvl && (b < 0 || pr[i] > pr[b])) b = i;
        return b;
    endfunction

    function logic [31:0] word(input int kind, input int r);
        logic [31:0] v;
        v = 32'h0;
        for (int k = 0; k < 16; k++) begin
            if (kind == 0) v[k] = flg[16*r+k] != 0;
            if (kind == 1) v[k] = en[16*r+k] != 0;
            if (kind == 2 && k < 4) v[4*k+:3] = 3'(pr[4*r+k]);
        end
        return v;
    endfunction

    task sync(input int q);
        bus(1'b1, 12'(256 + 4*(q/16)), word(0, q/16));
        bus(1'b1, 12'(512 + 4*(q/16)), word(1, q/16));
        bus(1'b1, 12'(768 + 4*(q/4)), word(2, q/4));
    endtask

    task fire(input logic [NS-1:0] mm);
        @(posedge hclk);
        src_event <= mm;
        for (int i = 0; i < NS; i++) if (mm[i]) flg[i] = 1;
        @(posedge hclk);
        src_event <= '0;
    endtask

    task take();
        int w, n0;
        w = pick();
        n0 = n_taken;
        while (n_taken == n0) @(posedge hclk);
        @(negedge hclk);
        check({21'h0, last}, {21'h0, 7'(w), 4'(pr[w])});
        check(32'(cpu_priority_level), 32'(pr[w]));
        check(32'(irq), 32'(msk[1]));
        rcheck(OFS_VLATCH, {20'h0, 4'(pr[w]), 1'b0, 7'(w)});
        rcheck(12'(256 + 4*(w/16)), word(0, w/16));
        flg[w] = 0;
        bus(1'b1, 12'(256 + 4*(w/16)), word(0, w/16));
        bus(1'b1, OFS_EVT_STAT, 32'h2);
        bus(1'b1, OFS_STATUS, 32'h0);
        lvl = 0;
        @(negedge hclk);
        check(32'(irq), 32'h0);
    endtask

    initial begin
        hresetn = 1'b0; hsel = 1'b1; hwrite = 1'b0; hsize = 3'h2; htrans = 2'b00;
        haddr = 32'h0; hwdata = 32'h0; src_event = '0; trap_event = '0;
        trap_raise_level = 1'b0; delay = 8'h00; rng = 32'hd7d2976f; msk = 32'h0; lvl = 0;
        for (int i = 0; i < NS; i++) begin
            flg[i] = 0; en[i] = 0; pr[i] = 0;
        end
        ofs = '{OFS_CTL1, OFS_CTL2, OFS_STATUS, OFS_CORE, OFS_VLATCH, OFS_EVT_STAT,
                OFS_EVT_MASK, 12'h020, 12'h100, 12'h320};
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (ofs[i]) rcheck(ofs[i], 32'h0);
        check(32'(hresp), 32'h0);
        $display("reset values done");
        bus(1'b1, OFS_CTL2, 32'hffff_ffff);
        rcheck(OFS_CTL2, 32'h8007);
        check({28'h0, alt_sel, edge_sel}, 32'hf);
        bus(1'b1, OFS_STATUS, 32'hffff_ffff);
        rcheck(OFS_STATUS, 32'h00e0);
        check(32'(cpu_priority_level), 32'h7);
        bus(1'b1, OFS_CORE, 32'hffff_ffff);
        rcheck(OFS_CORE, 32'h0004);
        bus(1'b1, OFS_CTL1, 32'h8000);
        bus(1'b1, OFS_STATUS, 32'h0040);
        rcheck(OFS_STATUS, 32'h00e0);
        rcheck(OFS_CTL1, 32'h8000);
        bus(1'b1, OFS_CTL1, 32'h0);
        bus(1'b1, OFS_STATUS, 32'h0);
        bus(1'b1, OFS_CORE, 32'h0);
        bus(1'b1, 12'h320, 32'h7777);
        rcheck(12'h320, 32'h0);
        $display("register access done");
        en[0] = 1; pr[0] = 7; lvl = 7;
        sync(0);
        bus(1'b1, OFS_STATUS, 32'h00e0);
        fire(1);
        repeat (8) @(posedge hclk);
        check(32'(cpu_req_valid), 32'h0);
        bus(1'b1, OFS_STATUS, 32'h00c0);
        lvl = 6;
        take();
        en[5] = 0; pr[5] = 3; delay = 8'h03;
        sync(5);
        fire(NS'(1) << 5);
        repeat (8) @(posedge hclk);
        check(32'(cpu_req_valid), 32'h0);
        en[5] = 1;
        sync(5);
        take();
        $display("blocking and enable done");
        msk = 32'h2;
        bus(1'b1, OFS_EVT_MASK, msk);
        for (int r = 0; r < 5; r++) begin
            m = '0;
            for (int j = 0; j < 3; j++) begin
                do s = int'(xs() % NS); while (!PRI_IMPL[s/4]);
                en[s] = 1; pr[s] = 1 + int'(xs() % 7); m[s] = 1'b1;
                sync(s);
            end
            delay <= 8'(xs() % 4);
            fire(m);
            while (pick() >= 0) take();
        end
        $display("random batches done");
        @(posedge hclk);
        trap_event <= 4'b0101;
        trap_raise_level <= 1'b1;
        @(posedge hclk);
        trap_event <= '0;
        trap_raise_level <= 1'b0;
        bus(1'b1, OFS_EVT_MASK, 32'h1);
        @(negedge hclk);
        check(32'(irq), 32'h1);
        check(32'(cpu_priority_level), 32'h8);
        rcheck(OFS_CTL1, 32'h000a);
        rcheck(OFS_CORE, 32'h0008);
        bus(1'b1, OFS_EVT_STAT, 32'h1);
        rcheck(OFS_EVT_STAT, 32'h0);
        check(32'(irq), 32'h0);
        $display("trap events done");
        close_out();
    end
endmodule
`default_nettype wire
